/* tb.sv */
// self-checking bench for the extended register bank
`timescale 1ns/100ps
module tb;
    logic                 ref_clk;
    logic                 sys_rst;
    logic                 cfg_wr;
    logic [11:0]          cfg_base;
    logic [1:0]           cfg_offset;
    logic                 io_wr;
    logic                 io_rd;
    logic [11:0]          io_addr;
    logic [15:0]          io_wdata;
    logic [7:0]           io_rdata;
    logic                 io_hit;
    logic [7:0]           misc_out_value;
    logic [9:0]           line_count;
    vxrb_pkg::vxrb_ctrl_t ctrl;
    logic [7:0]           img [64];
    logic [7:0]           exp_q [$];
    logic [31:0]          rng;
    logic [11:0]          base;
    logic [1:0]           ofs;
    logic [7:0]           d;
    logic [9:0]           lc;
    int                   mismatches;
    int                   tests_run;

    vxrb_bank i_vxrb_bank (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cfg_wr(cfg_wr), .cfg_base(cfg_base), .cfg_offset(cfg_offset),
        .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
        .misc_out_value(misc_out_value), .line_count(line_count),
        .ctrl(ctrl));
    vxrb_host i_vxrb_host (.ref_clk(ref_clk), .cfg_wr(cfg_wr),
        .cfg_base(cfg_base), .cfg_offset(cfg_offset), .io_wr(io_wr),
        .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction

    function automatic logic [7:0] wmask(input logic [5:0] idx);
        case (idx)
            6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h24, 6'h25,
            6'h2D, 6'h2E: return 8'hFF;
            6'h06: return vxrb_pkg::MASK_TEXT_FIFO_ROM;
            6'h20: return vxrb_pkg::MASK_DISP_FIFO_ROM;
            6'h23: return vxrb_pkg::MASK_ROM_TIME_A17;
            6'h26: return vxrb_pkg::MASK_DISP_MISC_OPT;
            6'h2B: return vxrb_pkg::MASK_WAIT_LOCK_DLY;
            6'h30: return vxrb_pkg::MASK_DISP_SKEW;
            default: return 8'h00;
        endcase
    endfunction

    task automatic fail(input string msg);
        mismatches++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_ctrl();
        vxrb_pkg::vxrb_ctrl_t e;
        // sample once the launching edge has settled
        @(negedge ref_clk);
        e.cpu_cmd_clocks      = img[6'h05][3:0];
        e.read_ready_delay    = img[6'h05][5:4];
        e.planar_latch_delay  = img[6'h05][6];
        e.blink_half_rate     = img[6'h05][7];
        e.text_fifo_depth     = img[6'h06][2:0];
        e.rom_read_clocks     = img[6'h06][6:4];
        e.display_fifo_thresh = img[6'h20][3:0];
        e.rom_access_time     = img[6'h23][2:0];
        e.cursor_addr_hi      = {img[6'h2D][1:0], img[6'h23][3], 1'b0};
        e.start_addr_hi       = {img[6'h2D][3:2], img[6'h23][4], 1'b0};
        e.char_map_addr_hi    = img[6'h2D][7:4];
        e.solid_underline     = img[6'h26][6];
        e.force_misc_zero     = img[6'h26][7];
        e.text_latch_delay    = img[6'h2B][6];
        e.write_page_hi       = img[6'h2E][1:0];
        e.read_page_hi        = img[6'h2E][3:2];
        e.hsync_skew          = img[6'h2E][7:5];
        e.de_skew_char        = img[6'h30][0];
        tests_run++;
        if (ctrl !== e)
            fail("control outputs");
    endtask

    task automatic rd_at(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_vxrb_host.rd(a);
    endtask

    // write through the port, track the image, then read it back
    task automatic put(input logic [5:0] idx, input logic [7:0] v);
        logic [7:0] m;
        m = wmask(idx);
        if (idx == 6'h05 && img[6'h2E][4] === 1'b1)
            m[3:0] = 4'h0;
        if (idx == 6'h06 && img[6'h24][4] === 1'b1)
            m[6:4] = 3'h0;
        img[idx] = (img[idx] & ~m) | (v & m);
        i_vxrb_host.wr(idx, ofs, v);
        check_ctrl();
        rd_at(base + 12'h001, img[idx]);
    endtask

    always @(posedge ref_clk) begin
        if (io_hit === 1'b1) begin
            tests_run++;
            if (exp_q.size() == 0)
                fail("unexpected read answer");
            else if (io_rdata !== exp_q.pop_front())
                fail("read data");
        end
    end

    initial begin
        repeat (8000) @(posedge ref_clk);
        fail("watchdog expired");
        print_verdict();
    end

    initial begin
        rng = 32'd17;
        base = vxrb_pkg::BASE_PORT_DEFAULT;
        ofs = vxrb_pkg::OFFSET_DEFAULT;
        mismatches = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        misc_out_value = 8'h00;
        line_count = 10'h000;
        foreach (img[i])
            img[i] = 8'h00;
        img[6'h05] = vxrb_pkg::RST_BUS_MEM_TIMING;
        img[6'h06] = vxrb_pkg::RST_TEXT_FIFO_ROM;
        img[6'h20] = vxrb_pkg::RST_DISP_FIFO_ROM;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check_ctrl();
        i_vxrb_host.configure(base, ofs);
        rd_at(base, 8'h00);
        for (int i = 0; i <= 48; i++)
            if (i != 8'h28 && i != 8'h29)
                put(6'(i), rnd());
        rd_at(base, {ofs, 6'h30});
        put(6'h2E, 8'h00);
        for (int k = 0; k < 4; k++) begin
            d = rnd();
            d[5:4] = 2'(k);
            put(6'h05, d);
        end
        put(6'h2E, 8'h10);
        put(6'h05, 8'hFF);
        put(6'h05, 8'h00);
        put(6'h2E, 8'hEF);
        put(6'h05, 8'h0A);
        put(6'h24, 8'h10);
        put(6'h06, 8'h77);
        put(6'h24, 8'h00);
        put(6'h06, 8'h45);
        i_vxrb_host.wr(6'h2D, ofs ^ 2'h1, ~img[6'h2D]);
        check_ctrl();
        rd_at(base + 12'h001, 8'h00);
        put(6'h01, img[6'h01]);
        d = rnd();
        lc = {d[1:0], rnd()};
        line_count <= lc;
        repeat (4) @(posedge ref_clk);
        i_vxrb_host.wr(6'h29, ofs, 8'hFF);
        rd_at(base + 12'h001, lc[7:0]);
        i_vxrb_host.wr(6'h28, ofs, 8'hFF);
        rd_at(base + 12'h001, {6'h00, lc[9:8]});
        d = rnd();
        misc_out_value <= d;
        put(6'h26, 8'h80);
        rd_at(vxrb_pkg::MISC_RD_PORT, {7'h00, d[0]});
        put(6'h26, 8'h40);
        rd_at(vxrb_pkg::MISC_RD_PORT, d);
        base = 12'h2D6;
        ofs = 2'h3;
        i_vxrb_host.configure(base, ofs);
        put(6'h02, rnd());
        repeat (4) @(posedge ref_clk);
        if (exp_q.size() != 0)
            fail("missing read answers");
        print_verdict();
    end
endmodule

/* vxrb_bank.sv */
// indexed extended register bank behind a programmable i/o port pair
`timescale 1ns/100ps
module vxrb_bank #(
    parameter logic [11:0] BASE_RESET = vxrb_pkg::BASE_PORT_DEFAULT,
    parameter logic [1:0]  OFS_RESET  = vxrb_pkg::OFFSET_DEFAULT
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         cfg_wr,
    input  wire logic [11:0]  cfg_base,
    input  wire logic [1:0]   cfg_offset,
    input  wire logic         io_wr,
    input  wire logic         io_rd,
    input  wire logic [11:0]  io_addr,
    input  wire logic [15:0]  io_wdata,
    output logic      [7:0]   io_rdata,
    output logic              io_hit,
    input  wire logic [7:0]   misc_out_value,
    input  wire logic [9:0]   line_count,
    output vxrb_pkg::vxrb_ctrl_t ctrl
);
    logic [11:0] base_port;
    logic [1:0]  index_ofs;
    logic [7:0]  extended_index;
    logic [7:0]  scratch [0:4];
    logic [7:0]  bus_memory_timing;
    logic [7:0]  text_fifo_rom_cycle;
    logic [7:0]  display_fifo_rom_width;
    logic [7:0]  rom_time_addr_bit17;
    logic [7:0]  rom_page_low;
    logic [7:0]  rom_page_high;
    logic [7:0]  display_misc_options;
    logic [7:0]  wait_state_lock_delay;
    logic [7:0]  upper_address_bits;
    logic [7:0]  page_pointer_hsync_skew;
    logic [7:0]  display_skew_misc;
    logic [9:0]  line_sync1;
    logic [9:0]  line_sync2;
    logic [9:0]  line_sync3;
    logic [9:0]  line_hold;
    logic        idx_port;
    logic        data_port;
    logic        wr16;
    logic [7:0]  wr_idx;
    logic [7:0]  wr_data;
    logic        wr_ok;
    logic [5:0]  wr_reg;
    logic [5:0]  rd_reg;
    logic        rd_ok;
    logic [7:0]  next_rdata;
    logic        next_hit;

    // base port and offset, written by firmware setup
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            base_port <= BASE_RESET;
            index_ofs <= OFS_RESET;
        end else if (cfg_wr) begin
            base_port <= cfg_base;
            index_ofs <= cfg_offset;
        end
    end

    assign idx_port  = (io_addr == base_port);
    assign data_port = (io_addr == base_port + 12'h001);
    // word write carries index low, data high
    assign wr16    = io_wr && idx_port;
    assign wr_idx  = io_wdata[7:0];
    assign wr_data = io_wdata[15:8];
    localparam int IDX_HI = vxrb_pkg::IDX_OFS_LSB + vxrb_pkg::IDX_OFS_W - 1;
    // offset bits must match the configured offset
    assign wr_ok  = wr16 &&
        (wr_idx[IDX_HI:vxrb_pkg::IDX_OFS_LSB] == index_ofs);
    assign wr_reg = wr_idx[5:0];
    assign rd_ok  = (extended_index[IDX_HI:vxrb_pkg::IDX_OFS_LSB]
                     == index_ofs);
    assign rd_reg = extended_index[5:0];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            extended_index <= vxrb_pkg::RST_ZERO;
        end else if (wr16) begin
            extended_index <= wr_idx;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_scr
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    scratch[g] <= vxrb_pkg::RST_ZERO;
                end else if (wr_ok && wr_reg == 6'(g)) begin
                    scratch[g] <= wr_data;
                end
            end
        end
    endgenerate

    // command clock field, locked by page register bit 4
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_memory_timing <= vxrb_pkg::RST_BUS_MEM_TIMING;
        end else if (wr_ok && wr_reg == vxrb_pkg::REG_BUS_MEM_TIMING) begin
            bus_memory_timing[7:4] <= wr_data[7:4];
            if (!page_pointer_hsync_skew[vxrb_pkg::CLK_LOCK]) begin
                bus_memory_timing[3:0] <= wr_data[3:0];
            end
        end
    end

    // text fifo and rom cycle, rom page lock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            text_fifo_rom_cycle <= vxrb_pkg::RST_TEXT_FIFO_ROM;
        end else if (wr_ok && wr_reg == vxrb_pkg::REG_TEXT_FIFO_ROM) begin
            text_fifo_rom_cycle[2:0] <= wr_data[2:0];
            if (!rom_page_low[vxrb_pkg::ROM_PAGE_LOCK]) begin
                text_fifo_rom_cycle[6:4] <= wr_data[6:4];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            display_fifo_rom_width  <= vxrb_pkg::RST_DISP_FIFO_ROM;
            rom_time_addr_bit17     <= vxrb_pkg::RST_ZERO;
            rom_page_low            <= vxrb_pkg::RST_ZERO;
            rom_page_high           <= vxrb_pkg::RST_ZERO;
            display_misc_options    <= vxrb_pkg::RST_ZERO;
            wait_state_lock_delay   <= vxrb_pkg::RST_ZERO;
            upper_address_bits      <= vxrb_pkg::RST_ZERO;
            page_pointer_hsync_skew <= vxrb_pkg::RST_ZERO;
            display_skew_misc       <= vxrb_pkg::RST_ZERO;
        end else if (wr_ok) begin
            case (wr_reg)
                vxrb_pkg::REG_DISP_FIFO_ROM: display_fifo_rom_width <=
                    wr_data & vxrb_pkg::MASK_DISP_FIFO_ROM;
                vxrb_pkg::REG_ROM_TIME_A17: rom_time_addr_bit17 <=
                    wr_data & vxrb_pkg::MASK_ROM_TIME_A17;
                vxrb_pkg::REG_ROM_PAGE_LOW: rom_page_low <= wr_data;
                vxrb_pkg::REG_ROM_PAGE_HIGH: rom_page_high <= wr_data;
                vxrb_pkg::REG_DISP_MISC_OPT: display_misc_options <=
                    wr_data & vxrb_pkg::MASK_DISP_MISC_OPT;
                vxrb_pkg::REG_WAIT_LOCK_DLY: wait_state_lock_delay <=
                    wr_data & vxrb_pkg::MASK_WAIT_LOCK_DLY;
                vxrb_pkg::REG_UPPER_ADDR: upper_address_bits <= wr_data;
                vxrb_pkg::REG_PAGE_HSYNC: page_pointer_hsync_skew <=
                    wr_data;
                vxrb_pkg::REG_DISP_SKEW_MISC: display_skew_misc <=
                    wr_data & vxrb_pkg::MASK_DISP_SKEW;
                default: ;
            endcase
        end
    end

    // line counter comes from another timing source
    // a word is taken only when two synchronised samples agree, so a
    // count caught mid-change with skewed bits never reaches the host
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            line_sync1 <= 10'h000;
            line_sync2 <= 10'h000;
            line_sync3 <= 10'h000;
            line_hold  <= 10'h000;
        end else begin
            line_sync1 <= line_count;
            line_sync2 <= line_sync1;
            line_sync3 <= line_sync2;
            if (line_sync2 == line_sync3) begin
                line_hold <= line_sync2;
            end
        end
    end

    // read mux, unmapped and reserved read as zero
    always_comb begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
        if (io_rd && idx_port) begin
            next_rdata = extended_index;
            next_hit   = 1'b1;
        end else if (io_rd && data_port) begin
            next_hit = 1'b1;
            if (rd_ok) begin
                case (rd_reg)
                    6'h00, 6'h01, 6'h02, 6'h03, 6'h04:
                        next_rdata = scratch[rd_reg[2:0]];
                    vxrb_pkg::REG_BUS_MEM_TIMING:
                        next_rdata = bus_memory_timing;
                    vxrb_pkg::REG_TEXT_FIFO_ROM:
                        next_rdata = text_fifo_rom_cycle;
                    vxrb_pkg::REG_DISP_FIFO_ROM:
                        next_rdata = display_fifo_rom_width;
                    vxrb_pkg::REG_ROM_TIME_A17:
                        next_rdata = rom_time_addr_bit17;
                    vxrb_pkg::REG_ROM_PAGE_LOW:
                        next_rdata = rom_page_low;
                    vxrb_pkg::REG_ROM_PAGE_HIGH:
                        next_rdata = rom_page_high;
                    vxrb_pkg::REG_DISP_MISC_OPT:
                        next_rdata = display_misc_options;
                    vxrb_pkg::REG_LINE_CNT_HIGH:
                        next_rdata = {6'h00, line_hold[9:8]};
                    vxrb_pkg::REG_LINE_CNT_LOW:
                        next_rdata = line_hold[7:0];
                    vxrb_pkg::REG_WAIT_LOCK_DLY:
                        next_rdata = wait_state_lock_delay;
                    vxrb_pkg::REG_UPPER_ADDR:
                        next_rdata = upper_address_bits;
                    vxrb_pkg::REG_PAGE_HSYNC:
                        next_rdata = page_pointer_hsync_skew;
                    vxrb_pkg::REG_DISP_SKEW_MISC:
                        next_rdata = display_skew_misc;
                    default: next_rdata = 8'h00;
                endcase
            end
        end else if (io_rd && io_addr == vxrb_pkg::MISC_RD_PORT) begin
            next_hit = 1'b1;
            if (display_misc_options[vxrb_pkg::FORCE_RD]) begin
                next_rdata = {7'h00, misc_out_value[0]};
            end else begin
                next_rdata = misc_out_value;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            io_rdata <= 8'h00;
            io_hit   <= 1'b0;
        end else begin
            io_rdata <= next_rdata;
            io_hit   <= next_hit;
        end
    end

    always_comb begin
        ctrl.cpu_cmd_clocks      = bus_memory_timing[3:0];
        ctrl.read_ready_delay    = bus_memory_timing[5:4];
        ctrl.planar_latch_delay  = bus_memory_timing[vxrb_pkg::PLANAR_DLY];
        ctrl.blink_half_rate     = bus_memory_timing[vxrb_pkg::BLINK_HALF];
        ctrl.text_fifo_depth     = text_fifo_rom_cycle[2:0];
        ctrl.rom_read_clocks     = text_fifo_rom_cycle[6:4];
        ctrl.display_fifo_thresh = display_fifo_rom_width[3:0];
        ctrl.rom_access_time     = rom_time_addr_bit17[2:0];
        ctrl.cursor_addr_hi      = {upper_address_bits[1:0],
                                    rom_time_addr_bit17[3], 1'b0};
        ctrl.start_addr_hi       = {upper_address_bits[3:2],
                                    rom_time_addr_bit17[4], 1'b0};
        ctrl.char_map_addr_hi    = upper_address_bits[7:4];
        ctrl.solid_underline     = display_misc_options[vxrb_pkg::SOLID_UL];
        ctrl.force_misc_zero     = display_misc_options[vxrb_pkg::FORCE_RD];
        ctrl.text_latch_delay    = wait_state_lock_delay[vxrb_pkg::TEXT_DLY];
        ctrl.write_page_hi       = page_pointer_hsync_skew[1:0];
        ctrl.read_page_hi        = page_pointer_hsync_skew[3:2];
        ctrl.hsync_skew          = page_pointer_hsync_skew[7:5];
        ctrl.de_skew_char        = display_skew_misc[0];
    end

    lock_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_ok && wr_reg == vxrb_pkg::REG_BUS_MEM_TIMING &&
         page_pointer_hsync_skew[4]) |=> $stable(bus_memory_timing[3:0]))
        else $error("locked clock field changed");
    rom_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_ok && wr_reg == vxrb_pkg::REG_TEXT_FIFO_ROM && rom_page_low[4])
        |=> $stable(text_fifo_rom_cycle[6:4]))
        else $error("locked rom field changed");
    scratch_store_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_ok && wr_reg == 6'h00) |=> (scratch[0] == $past(wr_data)))
        else $error("scratch not stored");
    reset_value_a: assert property (@(posedge ref_clk)
        sys_rst |=> (bus_memory_timing[3:0] == 4'h6 &&
        text_fifo_rom_cycle[2:0] == 3'h2 && display_fifo_rom_width == 8'h08))
        else $error("reset defaults wrong");
    rom_default_a: assert property (@(posedge ref_clk)
        sys_rst |=> text_fifo_rom_cycle[6:4] == 3'h3)
        else $error("rom cycle default wrong");
    force_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (io_rd && io_addr == vxrb_pkg::MISC_RD_PORT && !idx_port &&
         !data_port && display_misc_options[7]) |=> io_rdata[7:1] == 7'h00)
        else $error("misc readback not forced");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (text_fifo_rom_cycle[7] == 1'b0 && text_fifo_rom_cycle[3] == 1'b0
         && display_skew_misc[7:1] == 7'h00))
        else $error("reserved bit set");
    offset_check_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr16 && wr_idx[7:6] != index_ofs) |=> $stable(upper_address_bits))
        else $error("write with wrong offset took effect");

    // index port read returns the stored index byte
    sequence index_read_s;
        io_rd && idx_port;
    endsequence
    sequence index_answer_s;
        io_hit && io_rdata == $past(extended_index);
    endsequence
    index_read_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        index_read_s |=> index_answer_s)
        else $error("index readback wrong");
    // word write lands in the upper address register
    sequence addr_write_s;
        wr_ok && wr_reg == vxrb_pkg::REG_UPPER_ADDR;
    endsequence
    upper_write_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        addr_write_s |=> upper_address_bits == $past(wr_data))
        else $error("upper address bits not stored");
    offset_read_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (io_rd && data_port && !rd_ok) |=> (io_hit && io_rdata == 8'h00))
        else $error("wrong offset read not zero");
endmodule

/* vxrb_host.sv */
// host processor model issuing configuration and i/o port cycles
`timescale 1ns/100ps
module vxrb_host (
    input  wire logic ref_clk,
    output logic      cfg_wr,
    output logic [11:0] cfg_base,
    output logic [1:0]  cfg_offset,
    output logic        io_wr,
    output logic        io_rd,
    output logic [11:0] io_addr,
    output logic [15:0] io_wdata
);
    logic [11:0] base;

    initial begin
        cfg_wr     = 1'b0;
        cfg_base   = 12'h000;
        cfg_offset = 2'h0;
        io_wr      = 1'b0;
        io_rd      = 1'b0;
        io_addr    = 12'h000;
        io_wdata   = 16'h0000;
        base       = 12'h1CE;
    end

    // setup before access: the bench configures first
    task automatic configure(input logic [11:0] b, input logic [1:0] o);
        @(posedge ref_clk);
        cfg_wr     <= 1'b1;
        cfg_base   <= b;
        cfg_offset <= o;
        @(posedge ref_clk);
        cfg_wr     <= 1'b0;
        cfg_base   <= ~b;
        cfg_offset <= ~o;
        base = b;
    endtask

    // index byte low, data byte high in one word
    task automatic wr(input logic [5:0] idx, input logic [1:0] o,
                      input logic [7:0] d);
        @(posedge ref_clk);
        io_wr    <= 1'b1;
        io_addr  <= base;
        io_wdata <= {d, o, idx};
        @(posedge ref_clk);
        io_wr    <= 1'b0;
        io_addr  <= ~base;
        io_wdata <= ~{d, o, idx};
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge ref_clk);
        io_rd   <= 1'b1;
        io_addr <= a;
        @(posedge ref_clk);
        io_rd   <= 1'b0;
        io_addr <= ~a;
    endtask
endmodule

/* vxrb_pkg.sv */
// package for the extended display register bank
package vxrb_pkg;
    // index byte layout
    localparam int IDX_REG_LSB  = 0;
    localparam int IDX_REG_W    = 6;
    localparam int IDX_OFS_LSB  = 6;
    localparam int IDX_OFS_W    = 2;
    // register indices
    localparam logic [5:0] REG_SCRATCH_0      = 6'h00;
    localparam logic [5:0] REG_SCRATCH_4      = 6'h04;
    localparam logic [5:0] REG_BUS_MEM_TIMING = 6'h05;
    localparam logic [5:0] REG_TEXT_FIFO_ROM  = 6'h06;
    localparam logic [5:0] REG_DISP_FIFO_ROM  = 6'h20;
    localparam logic [5:0] REG_ROM_TIME_A17   = 6'h23;
    localparam logic [5:0] REG_ROM_PAGE_LOW   = 6'h24;
    localparam logic [5:0] REG_ROM_PAGE_HIGH  = 6'h25;
    localparam logic [5:0] REG_DISP_MISC_OPT  = 6'h26;
    localparam logic [5:0] REG_LINE_CNT_HIGH  = 6'h28;
    localparam logic [5:0] REG_LINE_CNT_LOW   = 6'h29;
    localparam logic [5:0] REG_WAIT_LOCK_DLY  = 6'h2B;
    localparam logic [5:0] REG_UPPER_ADDR     = 6'h2D;
    localparam logic [5:0] REG_PAGE_HSYNC     = 6'h2E;
    localparam logic [5:0] REG_DISP_SKEW_MISC = 6'h30;
    // writable-bit masks; other bits are reserved
    localparam logic [7:0] MASK_TEXT_FIFO_ROM = 8'h77;
    localparam logic [7:0] MASK_DISP_FIFO_ROM = 8'h7F;
    localparam logic [7:0] MASK_ROM_TIME_A17  = 8'h1F;
    localparam logic [7:0] MASK_DISP_MISC_OPT = 8'hC9;
    localparam logic [7:0] MASK_WAIT_LOCK_DLY = 8'hDF;
    localparam logic [7:0] MASK_DISP_SKEW     = 8'h01;
    // field positions
    localparam int PROCESSOR_CLOCK_LSB    = 0;
    localparam int RDRDY_LSB     = 4;
    localparam int PLANAR_DLY    = 6;
    localparam int BLINK_HALF    = 7;
    localparam int ROMCYC_LSB    = 4;
    localparam int ROM_PAGE_LOCK = 4;
    localparam int CLK_LOCK      = 4;
    localparam int SOLID_UL      = 6;
    localparam int FORCE_RD      = 7;
    localparam int TEXT_DLY      = 6;
    localparam int HSKEW_LSB     = 5;
    // reset values
    localparam logic [7:0] RST_BUS_MEM_TIMING = 8'h06;
    localparam logic [7:0] RST_TEXT_FIFO_ROM  = 8'h32;
    localparam logic [7:0] RST_DISP_FIFO_ROM  = 8'h08;
    localparam logic [7:0] RST_ZERO           = 8'h00;
    // default base port and offset after firmware setup
    localparam logic [11:0] BASE_PORT_DEFAULT = 12'h1CE;
    localparam logic [1:0]  OFFSET_DEFAULT    = 2'h2;
    localparam logic [11:0] MISC_RD_PORT      = 12'h3CC;

    typedef struct packed {
        logic [3:0] cpu_cmd_clocks;
        logic [1:0] read_ready_delay;
        logic       planar_latch_delay;
        logic       blink_half_rate;
        logic [2:0] text_fifo_depth;
        logic [2:0] rom_read_clocks;
        logic [3:0] display_fifo_thresh;
        logic [2:0] rom_access_time;
        logic [3:0] cursor_addr_hi;
        logic [3:0] start_addr_hi;
        logic [3:0] char_map_addr_hi;
        logic       solid_underline;
        logic       force_misc_zero;
        logic       text_latch_delay;
        logic [1:0] write_page_hi;
        logic [1:0] read_page_hi;
        logic [2:0] hsync_skew;
        logic       de_skew_char;
    } vxrb_ctrl_t;
endpackage
